/* File: orx_pkg.sv */
// Package of constants and types for the OR, return and rotate executor.
// Overview of operation
// - OR immediate into working, update zero
// - OR working into memory, update zero
// - Subroutine exit pops counter, no flags
// - Return pops counter, loads immediate working
// - Interrupt exit pops counter, sets enable
// - Pending interrupt serviced before main program
// - Rotate memory left in place, no flags
// - Rotate memory left into working, no flags
package orx_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W   = 11;
    localparam int ADDR_W = 7;
    localparam int MEM_WORDS = 128;
    localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
    localparam int MSB_POS = 7;

    // Operation codes presented on the op port.
    typedef enum logic [2:0] {
        ORX_OP_NONE  = 3'h0,
        ORX_OP_ORI   = 3'h1,
        ORX_OP_ORMEM = 3'h2,
        ORX_OP_SRET  = 3'h3,
        ORX_OP_RETW  = 3'h4,
        ORX_OP_IRET  = 3'h5,
        ORX_OP_RLM   = 3'h6,
        ORX_OP_RLW   = 3'h7
    } orx_op_t;

    // Execution phases, one bit changing per step except WRITE back to IDLE.
    typedef enum logic [1:0] {
        ORX_IDLE  = 2'b00,
        ORX_READ  = 2'b01,
        ORX_WRITE = 2'b11
    } orx_state_t;
endpackage

/* File: orx_mem.sv */
`timescale 1ns/1ps
// Data memory with registered read data.
module orx_mem
    import orx_pkg::*;
#(
    parameter int WORDS = MEM_WORDS,
    parameter int AW    = ADDR_W
) (
    input  wire logic              sys_clk,
    input  wire logic              we,
    input  wire logic [AW-1:0]     addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [DATA_W-1:0] rdata
);
    // Contents start cleared, so the first access reads a defined byte.
    logic [DATA_W-1:0] mem_r [WORDS] = '{default: '0};

    // Refuse a depth the address cannot reach.
    if (WORDS > (1 << AW)) begin : g_chk
        $error("orx_mem: depth exceeds address range.");
    end

    // Synchronous write and registered read.
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem_r[addr] <= wdata;
        end
        rdata <= mem_r[addr];
    end
endmodule // orx_mem

/* File: orx_exec.sv */
`timescale 1ns/1ps
// Executor for OR, return and rotate instructions of the core.
module orx_exec
    import orx_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    input  wire logic              op_valid,
    input  wire orx_op_t           op,
    input  wire logic [DATA_W-1:0] imm,
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic [PC_W-1:0]   stack_top,
    input  wire logic              irq_pending,
    output logic                   busy,
    output logic                   done,
    output logic [DATA_W-1:0]      working_register,
    output logic                   zero_flag,
    output logic                   master_interrupt_enable,
    output logic                   stack_pop,
    output logic                   pc_load,
    output logic [PC_W-1:0]        pc_value,
    output logic                   irq_enter
);
    // Module state apart from the reset synchronizer.
    typedef struct packed {
        orx_state_t        st;
        orx_op_t           op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] work;
        logic              zero;
        logic              mie;
        logic              busy;
        logic              done;
        logic              pop;
        logic              pcld;
        logic [PC_W-1:0]   pc;
        logic              irq;
        logic              we;
        logic [DATA_W-1:0] wdata;
    } orx_regs_t;

    orx_regs_t         s_r;
    orx_regs_t         s_nxt;
    logic [1:0]        rst_sync_r;
    logic              rst_n_i;
    logic [DATA_W-1:0] rdata;
    logic [ADDR_W-1:0] maddr;

    // Reset release through two flip-flops.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n_i = rst_sync_r[1];

    // Memory addressed by the latched operand during access phases.
    assign maddr = (s_r.st == ORX_IDLE) ? mem_addr : s_r.addr;

    orx_mem #(.WORDS(MEM_WORDS), .AW(ADDR_W)) u_mem (
        .sys_clk (sys_clk),
        .we      (s_r.we),
        .addr    (s_r.addr),
        .wdata   (s_r.wdata),
        .rdata   (rdata)
    );

    // Rotate left by one with the top bit wrapping round.
    function automatic logic [DATA_W-1:0] rotl(input logic [DATA_W-1:0] v);
        rotl = {v[MSB_POS-1:0], v[MSB_POS]};
    endfunction

    // Next-state logic for all operations.
    always_comb begin
        logic [DATA_W-1:0] res;
        res = '0;
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.pop = 1'b0;
        s_nxt.pcld = 1'b0;
        s_nxt.irq = 1'b0;
        s_nxt.we = 1'b0;
        case (s_r.st)
            ORX_IDLE: begin
                if (op_valid) begin
                    s_nxt.op = op;
                    s_nxt.addr = maddr;
                    case (op)
                        ORX_OP_ORI: begin
                            res = s_r.work | imm;
                            s_nxt.work = res;
                            s_nxt.zero = (res == '0);
                            s_nxt.done = 1'b1;
                        end
                        ORX_OP_SRET: begin
                            s_nxt.pc = stack_top;
                            s_nxt.pop = 1'b1;
                            s_nxt.pcld = 1'b1;
                            s_nxt.done = 1'b1;
                        end
                        ORX_OP_RETW: begin
                            s_nxt.pc = stack_top;
                            s_nxt.pop = 1'b1;
                            s_nxt.pcld = 1'b1;
                            s_nxt.work = imm;
                            s_nxt.done = 1'b1;
                        end
                        ORX_OP_IRET: begin
                            s_nxt.pc = stack_top;
                            s_nxt.pop = 1'b1;
                            s_nxt.pcld = 1'b1;
                            s_nxt.mie = 1'b1;
                            s_nxt.irq = irq_pending;
                            s_nxt.done = 1'b1;
                        end
                        ORX_OP_ORMEM, ORX_OP_RLM, ORX_OP_RLW: begin
                            s_nxt.st = ORX_READ;
                            s_nxt.busy = 1'b1;
                        end
                        default: begin
                            s_nxt.done = 1'b0;
                        end
                    endcase
                end
            end
            ORX_READ: begin
                // Address registered into memory; read data next cycle.
                s_nxt.st = ORX_WRITE;
            end
            ORX_WRITE: begin
                s_nxt.st = ORX_IDLE;
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
                case (s_r.op)
                    ORX_OP_ORMEM: begin
                        res = s_r.work | rdata;
                        s_nxt.wdata = res;
                        s_nxt.we = 1'b1;
                        s_nxt.zero = (res == '0);
                    end
                    ORX_OP_RLM: begin
                        s_nxt.wdata = rotl(rdata);
                        s_nxt.we = 1'b1;
                    end
                    ORX_OP_RLW: begin
                        s_nxt.work = rotl(rdata);
                    end
                    default: begin
                        s_nxt.done = 1'b0;
                    end
                endcase
            end
            default: begin
                s_nxt.st = ORX_IDLE;
                s_nxt.busy = 1'b0;
            end
        endcase
    end

    // State register.
    always_ff @(posedge sys_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '{st: ORX_IDLE, op: ORX_OP_NONE, work: WORK_RESET,
                     default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = s_r.busy;
    assign done = s_r.done;
    assign working_register = s_r.work;
    assign zero_flag = s_r.zero;
    assign master_interrupt_enable = s_r.mie;
    assign stack_pop = s_r.pop;
    assign pc_load = s_r.pcld;
    assign pc_value = s_r.pc;
    assign irq_enter = s_r.irq;

    ori_result_a: assert property (@(posedge sys_clk) disable iff (!rst_n_i)
        (s_r.st == ORX_IDLE && op_valid && op == ORX_OP_ORI) |=>
        working_register == ($past(working_register) | $past(imm))
        && zero_flag == (working_register == '0))
        else $error("OR immediate result wrong.");
    ormem_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n_i)
        (s_r.st == ORX_WRITE && s_r.op == ORX_OP_ORMEM) |=>
        s_r.we && s_r.wdata == ($past(s_r.work) | $past(rdata))
        && $stable(working_register))
        else $error("OR into memory wrong.");
    sret_pop_a: assert property (@(posedge sys_clk) disable iff (!rst_n_i)
        (s_r.st == ORX_IDLE && op_valid && op == ORX_OP_SRET) |=>
        pc_load && stack_pop && pc_value == $past(stack_top)
        && $stable(zero_flag))
        else $error("Subroutine exit wrong.");
    retw_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n_i)
        (s_r.st == ORX_IDLE && op_valid && op == ORX_OP_RETW) |=>
        pc_load && working_register == $past(imm))
        else $error("Return with immediate wrong.");
    iret_enable_a: assert property (@(posedge sys_clk) disable iff (!rst_n_i)
        (s_r.st == ORX_IDLE && op_valid && op == ORX_OP_IRET) |=>
        master_interrupt_enable && pc_load)
        else $error("Interrupt exit enable not set.");
    iret_pending_a: assert property (@(posedge sys_clk) disable iff (!rst_n_i)
        (s_r.st == ORX_IDLE && op_valid && op == ORX_OP_IRET
         && irq_pending) |=> irq_enter && pc_load)
        else $error("Pending interrupt not entered.");
    rlm_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n_i)
        (s_r.st == ORX_WRITE && s_r.op == ORX_OP_RLM) |=>
        s_r.we && s_r.wdata == {$past(rdata[6:0]), $past(rdata[7])}
        && $stable(zero_flag))
        else $error("Rotate in place wrong.");
    rlw_work_a: assert property (@(posedge sys_clk) disable iff (!rst_n_i)
        (s_r.st == ORX_WRITE && s_r.op == ORX_OP_RLW) |=>
        !s_r.we && working_register ==
        {$past(rdata[6:0]), $past(rdata[7])})
        else $error("Rotate into working wrong.");
endmodule // orx_exec

/* File: orx_exec_tb.sv */
`timescale 1ns/1ps
// Self-checking testbench for the OR, return and rotate executor.
module orx_exec_tb;
    import orx_pkg::*;

    typedef struct {
        logic [DATA_W-1:0] w;
        logic              z;
        logic              mie;
        logic [PC_W-1:0]   pc;
        bit                pc_chk;
    } orx_exp_t;

    logic              sys_clk = 1'b0;
    logic              reset_n = 1'b0;
    logic              op_valid = 1'b0;
    orx_op_t           op = ORX_OP_NONE;
    logic [DATA_W-1:0] imm = 8'h00;
    logic [ADDR_W-1:0] mem_addr = 7'h00;
    logic [PC_W-1:0]   stack_top = 11'h000;
    logic              irq_pending = 1'b0;
    logic              busy;
    logic              done;
    logic [DATA_W-1:0] working_register;
    logic              zero_flag;
    logic              master_interrupt_enable;
    logic              stack_pop;
    logic              pc_load;
    logic [PC_W-1:0]   pc_value;
    logic              irq_enter;
    orx_exp_t          exp_q[$];
    logic [DATA_W-1:0] bm[MEM_WORDS] = '{default: 8'h00};
    logic [DATA_W-1:0] m_w = 8'h00;
    logic              m_z = 1'b0;
    logic              m_mie = 1'b0;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    int pops = 0;
    int loads = 0;
    int enters = 0;
    int exp_rets = 0;
    int exp_enters = 0;

    orx_exec dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
        .op_valid(op_valid), .op(op), .imm(imm), .mem_addr(mem_addr),
        .stack_top(stack_top), .irq_pending(irq_pending), .busy(busy),
        .done(done), .working_register(working_register),
        .zero_flag(zero_flag),
        .master_interrupt_enable(master_interrupt_enable),
        .stack_pop(stack_pop), .pc_load(pc_load), .pc_value(pc_value),
        .irq_enter(irq_enter));

    // Free-running 10 MHz clock.
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    // Compares one value and reports a mismatch at once.
    task automatic check(string nm, logic [15:0] ex, logic [15:0] got);
        n_tests++;
        if (got !== ex) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Drives one request at a falling edge and notes its expected result.
    task automatic issue(orx_op_t o, logic [7:0] i, logic [6:0] a,
                         logic irq);
        orx_exp_t e;
        logic     memop;
        int       k;
        memop = (o == ORX_OP_ORMEM || o == ORX_OP_RLM || o == ORX_OP_RLW);
        op_valid = 1'b1;
        op = o;
        imm = i;
        mem_addr = a;
        irq_pending = irq;
        stack_top = 11'($urandom);
        e.pc_chk = 1'b0;
        case (o)
            ORX_OP_ORI: m_w = m_w | i;
            ORX_OP_ORMEM: bm[a] = m_w | bm[a];
            ORX_OP_RETW: m_w = i;
            ORX_OP_IRET: m_mie = 1'b1;
            ORX_OP_RLM: bm[a] = {bm[a][6:0], bm[a][7]};
            ORX_OP_RLW: m_w = {bm[a][6:0], bm[a][7]};
            default: ;
        endcase
        if (o == ORX_OP_ORI) m_z = (m_w == 8'h00);
        if (o == ORX_OP_ORMEM) m_z = (bm[a] == 8'h00);
        if (o == ORX_OP_SRET || o == ORX_OP_RETW || o == ORX_OP_IRET) begin
            e.pc_chk = 1'b1;
            exp_rets++;
        end
        if (o == ORX_OP_IRET && irq) exp_enters++;
        e.w = m_w;
        e.z = m_z;
        e.mie = m_mie;
        e.pc = stack_top;
        if (o != ORX_OP_NONE) exp_q.push_back(e);
        @(negedge sys_clk);
        if (memop) begin
            op_valid = 1'b0;
            check("busy", 16'h0001, 16'(busy));
            k = 0;
            do begin
                @(negedge sys_clk);
                k++;
            end while (busy === 1'b1 && k < 10);
        end
    endtask

    // Watches completions and compares them with the oldest note.
    always @(negedge sys_clk) begin : mon_b
        orx_exp_t e;
        if (reset_n) begin
            pops += int'(stack_pop === 1'b1);
            loads += int'(pc_load === 1'b1);
            enters += int'(irq_enter === 1'b1);
            if (done === 1'b1 && exp_q.size() == 0) begin
                check("done_unexpected", 16'h0000, 16'h0001);
            end else if (done === 1'b1) begin
                e = exp_q.pop_front();
                check("working_register", 16'(e.w), 16'(working_register));
                check("zero_flag", 16'(e.z), 16'(zero_flag));
                check("master_interrupt_enable", 16'(e.mie),
                      16'(master_interrupt_enable));
                if (e.pc_chk) check("pc_value", 16'(e.pc), 16'(pc_value));
            end
        end
    end

    // Cuts a hang short.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end

    // Main sequence.
    initial begin
        void'($urandom(32'hEA7A));
        repeat (10) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        issue(ORX_OP_RETW, 8'h81, 7'h15, 1'b0);
        issue(ORX_OP_ORMEM, 8'h00, 7'h15, 1'b0);
        issue(ORX_OP_RETW, 8'h00, 7'h00, 1'b0);
        issue(ORX_OP_ORI, 8'h00, 7'h00, 1'b0);
        issue(ORX_OP_ORMEM, 8'h00, 7'h15, 1'b0);
        issue(ORX_OP_RLM, 8'h00, 7'h15, 1'b0);
        issue(ORX_OP_RLW, 8'h00, 7'h15, 1'b0);
        issue(ORX_OP_RETW, 8'h00, 7'h00, 1'b0);
        issue(ORX_OP_ORMEM, 8'h00, 7'h40, 1'b0);
        issue(ORX_OP_RLW, 8'h00, 7'h15, 1'b0);
        issue(ORX_OP_NONE, 8'h5A, 7'h00, 1'b0);
        for (int k = 0; k < 8; k++) begin
            issue(ORX_OP_RETW, 8'h00, 7'h00, 1'b0);
            issue(ORX_OP_ORI, 8'($urandom) & 8'($urandom), 7'h00,
                  1'b0);
            issue(ORX_OP_ORI, 8'($urandom), 7'h00, 1'b0);
        end
        issue(ORX_OP_SRET, 8'hA5, 7'h00, 1'b0);
        issue(ORX_OP_IRET, 8'h3C, 7'h00, 1'b0);
        issue(ORX_OP_IRET, 8'h00, 7'h00, 1'b1);
        issue(ORX_OP_SRET, 8'h00, 7'h00, 1'b1);
        op_valid = 1'b0;
        irq_pending = 1'b0;
        repeat (6) @(negedge sys_clk);
        check("stack_pop_count", 16'(exp_rets), 16'(pops));
        check("pc_load_count", 16'(exp_rets), 16'(loads));
        check("irq_enter_count", 16'(exp_enters), 16'(enters));
        check("pending_notes", 16'h0000, 16'(exp_q.size()));
        summarize();
    end
endmodule // orx_exec_tb
